/* File: src/vac_attribute_controller.sv */
// Attribute controller: host index/data port, palette and pixel path.
`timescale 1ns/1ps
module vac_attribute_controller
  import vac_pkg::*;
(
  input wire logic clock,
  input wire logic rst_n,
  // Host I/O port
  input wire logic [15:0] ioAddr,
  input wire logic ioRd,
  input wire logic ioWr,
  input wire logic [7:0] ioWdata,
  output logic [7:0] ioRdata,
  // 1 selects the wide pixel bus, 0 the 8-bit pixel mode
  input wire logic pixelWidthCtrl,
  // Text serializer
  input wire logic fontDot,
  input wire logic ninthColumn,
  input wire logic eighthDot,
  input wire logic cursorDot,
  input wire logic underlineRow,
  input wire logic [7:0] charCode,
  input wire logic [7:0] attrByte,
  // Graphics serializer
  input wire logic [3:0] videoNibble,
  // Display timing
  input wire logic borderActive,
  input wire logic verticalRetracePulse,
  input wire logic lineCmpMatch,
  input wire logic vsyncStart,
  // Video out
  output logic [7:0] pixelOut,
  output logic pixelStrobe,
  output logic [3:0] panOut
);
  vac_timing_if tim();

  logic [5:0] index_q, index_d;
  logic indexDataToggle_q, indexDataToggle_d;
  logic [5:0] palette_q [PAL_ENTRIES];
  logic [5:0] palette_d [PAL_ENTRIES];
  logic [7:0] modeCtrl_q, modeCtrl_d;
  logic [7:0] border_q, border_d;
  logic [3:0] pan_q, pan_d;
  logic [3:0] padding_q, padding_d;
  logic [7:0] ioRdata_q, ioRdata_d;

  logic eightBitMode;
  logic palHostBlocked;
  logic statusRead;
  logic indexWrite;
  logic dataWrite;

  function automatic logic inLineGfx(input logic [7:0] code);
    inLineGfx = (code >= LGC_FIRST) && (code <= LGC_LAST);
  endfunction : inLineGfx

  function automatic logic isPalIdx(input logic [4:0] idx);
    isPalIdx = idx <= IDX_PAL_LAST;
  endfunction : isPalIdx

  assign eightBitMode = ~pixelWidthCtrl;
  // Palette access is split between host and display only in 8-bit mode
  assign palHostBlocked = eightBitMode && index_q[IDX_PAL_EN_BIT];
  assign statusRead = ioRd && (ioAddr == ADDR_STAT_MONO || ioAddr == ADDR_STAT_COLOR);
  assign indexWrite = ioWr && (ioAddr == ADDR_INDEX) && !indexDataToggle_q;
  assign dataWrite = ioWr && (ioAddr == ADDR_INDEX) && indexDataToggle_q;

  // Host access: toggle, index and register writes
  always_comb begin
    indexDataToggle_d = indexDataToggle_q;
    if (ioWr && ioAddr == ADDR_INDEX) begin
      indexDataToggle_d = ~indexDataToggle_q;
    end
    // Reads at the index and data ports leave the toggle as it was
    // Status read wins over a same-cycle write to the shared port
    if (statusRead) begin
      indexDataToggle_d = 1'b0;
    end
    index_d = index_q;
    if (indexWrite) begin
      index_d = ioWdata[5:0];
    end
  end

  always_comb begin
    palette_d = palette_q;
    modeCtrl_d = modeCtrl_q;
    border_d = border_q;
    pan_d = pan_q;
    padding_d = padding_q;
    if (dataWrite) begin
      if (isPalIdx(index_q[4:0])) begin
        if (!palHostBlocked) begin
          palette_d[index_q[3:0]] = ioWdata[5:0];
        end
      end else begin
        unique case (index_q[4:0])
          IDX_MODE: modeCtrl_d = ioWdata & MODE_WR_MASK;
          IDX_BORDER: border_d = ioWdata;
          IDX_PAN: pan_d = ioWdata[3:0];
          IDX_PAD: padding_d = ioWdata[3:0];
          default: ;
        endcase
      end
    end
  end

  // Read data is latched one edge after the read strobe
  always_comb begin
    ioRdata_d = ioRdata_q;
    if (ioRd && ioAddr == ADDR_INDEX) begin
      ioRdata_d = {2'b00, index_q};
    end else if (ioRd && ioAddr == ADDR_DATA_RD) begin
      ioRdata_d = 8'h00;
      if (isPalIdx(index_q[4:0])) begin
        if (!palHostBlocked) begin
          ioRdata_d = {2'b00, palette_q[index_q[3:0]]};
        end
      end else begin
        unique case (index_q[4:0])
          IDX_MODE: ioRdata_d = modeCtrl_q;
          IDX_BORDER: ioRdata_d = border_q;
          IDX_PAN: ioRdata_d = {4'h0, pan_q};
          IDX_PAD: ioRdata_d = {4'h0, padding_q};
          default: ioRdata_d = 8'h00;
        endcase
      end
    end
  end

  // Index and toggle
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      index_q <= RST_INDEX;
      indexDataToggle_q <= 1'b0;
    end else begin
      index_q <= index_d;
      indexDataToggle_q <= indexDataToggle_d;
    end
  end

  // Palette zeroed too, so the first frames after reset are defined
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      modeCtrl_q <= RST_MODE;
      border_q <= RST_BORDER;
      pan_q <= RST_PAN;
      padding_q <= RST_PAD;
      for (int i = 0; i < PAL_ENTRIES; i++) begin
        palette_q[i] <= RST_PALETTE;
      end
    end else begin
      modeCtrl_q <= modeCtrl_d;
      border_q <= border_d;
      pan_q <= pan_d;
      padding_q <= padding_d;
      palette_q <= palette_d;
    end
  end

  // Read data holds between reads, so status polls leave it alone
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      ioRdata_q <= 8'h00;
    end else begin
      ioRdata_q <= ioRdata_d;
    end
  end

  assign ioRdata = ioRdata_q;

  // Blink and top-panning timer
  assign tim.retracePulse = verticalRetracePulse;
  assign tim.lineCmpMatch = lineCmpMatch;
  assign tim.vsyncStart = vsyncStart;
  assign tim.topPanEn = modeCtrl_q[MODE_TOPPAN_BIT];

  vac_blink_timer u_timer (
    .clock(clock),
    .rst_n(rst_n),
    .tim(tim)
  );

  // Colour code selection
  logic [3:0] fgCode;
  logic [3:0] bgCode;
  logic textDot;
  logic [3:0] textCode;
  logic [3:0] gfxCode;
  logic [3:0] colorCode;

  always_comb begin
    fgCode = attrByte[3:0];
    bgCode = attrByte[7:4];
    if (modeCtrl_q[MODE_BLINK_BIT]) begin
      bgCode = {1'b0, attrByte[6:4]};
    end
    // Dot nine repeats dot eight only for box-drawing codes
    if (ninthColumn) begin
      textDot = modeCtrl_q[MODE_LGC_BIT] && inLineGfx(charCode) && eighthDot;
    end else begin
      textDot = fontDot;
    end
    // Monochrome decode reshapes the codes before blink and cursor apply
    if (modeCtrl_q[MODE_MONO_BIT]) begin
      fgCode = {attrByte[3], 3'h7};
      bgCode = 4'h0;
      if (attrByte[6:4] == 3'h7 && attrByte[2:0] == 3'h0) begin
        fgCode = 4'h0;
        bgCode = {~modeCtrl_q[MODE_BLINK_BIT] & attrByte[7], 3'h7};
      end else if (attrByte[6:0] == 7'h00) begin
        fgCode = 4'h0;
      end else if (attrByte[2:0] == 3'h1 && underlineRow) begin
        textDot = 1'b1;
      end
    end
    // Blinking characters show background during the off half
    if (modeCtrl_q[MODE_BLINK_BIT] && attrByte[7] && tim.charBlinkOff) begin
      textDot = 1'b0;
    end
    if (cursorDot && tim.cursorBlinkOn) begin
      textDot = 1'b1;
    end
    textCode = textDot ? fgCode : bgCode;
    gfxCode = videoNibble;
    if (modeCtrl_q[MODE_BLINK_BIT] && tim.charBlinkOff) begin
      gfxCode[3] = ~videoNibble[3];
    end
    colorCode = modeCtrl_q[MODE_GFX_BIT] ? gfxCode : textCode;
  end

  // Palette translation and upper bits
  logic [5:0] palEntry;
  logic [1:0] v54;
  logic [7:0] paletteByte;

  always_comb begin
    palEntry = palette_q[colorCode];
    v54 = modeCtrl_q[MODE_V54_BIT] ? padding_q[1:0] : palEntry[5:4];
    paletteByte = {padding_q[3:2], v54, palEntry[3:0]};
  end

  // Output stage; 256-colour mode emits one byte per two dots
  vac_phase_type phase_q, phase_d;
  logic [3:0] firstNibble_q, firstNibble_d;
  logic [7:0] pixelOut_q, pixelOut_d;
  logic pixelStrobe_q, pixelStrobe_d;
  logic [3:0] panOut_q, panOut_d;

  always_comb begin
    phase_d = PH_FIRST;
    firstNibble_d = firstNibble_q;
    pixelOut_d = pixelOut_q;
    pixelStrobe_d = 1'b0;
    if (eightBitMode && borderActive) begin
      pixelOut_d = border_q;
      pixelStrobe_d = 1'b1;
    end else if (eightBitMode && !index_q[IDX_PAL_EN_BIT]) begin
      // Display is cut off from the palette while the host owns it
      pixelOut_d = border_q;
      pixelStrobe_d = 1'b1;
    end else if (modeCtrl_q[MODE_BYTE_BIT]) begin
      unique case (phase_q)
        PH_FIRST: begin
          firstNibble_d = colorCode;
          phase_d = PH_SECOND;
        end
        PH_SECOND: begin
          pixelOut_d = {firstNibble_q, colorCode};
          pixelStrobe_d = 1'b1;
          phase_d = PH_FIRST;
        end
      endcase
    end else begin
      pixelOut_d = paletteByte;
      pixelStrobe_d = 1'b1;
    end
    // Pan output lags the hold register by one dot
    panOut_d = tim.panZero ? 4'h0 : pan_q;
  end

  always_ff @(posedge clock) begin
    if (!rst_n) begin
      phase_q <= PH_FIRST;
      firstNibble_q <= 4'h0;
      pixelOut_q <= 8'h00;
      pixelStrobe_q <= 1'b0;
      panOut_q <= 4'h0;
    end else begin
      phase_q <= phase_d;
      firstNibble_q <= firstNibble_d;
      pixelOut_q <= pixelOut_d;
      pixelStrobe_q <= pixelStrobe_d;
      panOut_q <= panOut_d;
    end
  end

  assign pixelOut = pixelOut_q;
  assign pixelStrobe = pixelStrobe_q;
  assign panOut = panOut_q;
endmodule : vac_attribute_controller

/* File: src/vac_blink_timer.sv */
// Retrace-paced blink divider and top-panning hold.
`timescale 1ns/1ps
module vac_blink_timer
  import vac_pkg::*;
(
  input wire logic clock,
  input wire logic rst_n,
  vac_timing_if.timer tim
);
  logic [BLINK_W-1:0] blinkCnt_q, blinkCnt_d;
  logic panZero_q, panZero_d;

  always_comb begin
    blinkCnt_d = blinkCnt_q;
    if (tim.retracePulse) begin
      blinkCnt_d = blinkCnt_q + 1'b1;
    end
    panZero_d = panZero_q;
    // Sync ends the hold, so a match in the same cycle starts a new one
    if (tim.vsyncStart) begin
      panZero_d = 1'b0;
    end
    if (tim.lineCmpMatch && tim.topPanEn) begin
      panZero_d = 1'b1;
    end
    if (!tim.topPanEn) begin
      panZero_d = 1'b0;
    end
  end

  always_ff @(posedge clock) begin
    if (!rst_n) begin
      blinkCnt_q <= '0;
      panZero_q <= 1'b0;
    end else begin
      blinkCnt_q <= blinkCnt_d;
      panZero_q <= panZero_d;
    end
  end

  assign tim.charBlinkOff = blinkCnt_q[CHAR_BLINK_BIT];
  assign tim.cursorBlinkOn = ~blinkCnt_q[CURSOR_BLINK_BIT];
  assign tim.panZero = panZero_q;
endmodule : vac_blink_timer

/* File: src/vac_pkg.sv */
// Constants, field positions and types of the attribute controller.
// Summary of operation
// - A read at either status port presets the toggle to index.
// - Every write to the shared port flips the index/data toggle.
// - Reads at the index or data-read port leave the toggle alone.
// - Lower port reads back the index, next port the indexed register.
// - Index bits 4-0 pick the register reached by data accesses.
// - Index bit 5 clear in 8-bit mode: display drops palette, host may access it.
// - Sixteen 6-bit palette entries drive secondary and primary red, green, blue.
// - Mode bit 0 selects text attributes or graphics colours.
// - Mode bit 1 selects monochrome or colour text attributes.
// - Line graphics codes C0H-DFH copy dot eight into dot nine.
// - Mode bit 3 makes attribute bit 7 blink, else background intensity.
// - Blink divides retrace by 32; graphics blink inverts colour bit 3.
// - Text cursor blinks eight retraces on, eight off.
// - Top panning zeroes pan from line compare until vertical sync.
// - 256-colour mode pairs two nibbles into one byte at half rate.
// - Video bits 7-6 from padding 3-2; bits 5-4 palette or padding 1-0.
// - Mode control and border colour reset to zero.
// - Border colour is output around the active area in 8-bit mode.
package vac_pkg;
  localparam logic [15:0] ADDR_INDEX = 16'h03C0;
  localparam logic [15:0] ADDR_DATA_RD = 16'h03C1;
  localparam logic [15:0] ADDR_STAT_MONO = 16'h03BA;
  localparam logic [15:0] ADDR_STAT_COLOR = 16'h03DA;

  localparam logic [4:0] IDX_PAL_LAST = 5'h0F;
  localparam logic [4:0] IDX_MODE = 5'h10;
  localparam logic [4:0] IDX_BORDER = 5'h11;
  localparam logic [4:0] IDX_PAN = 5'h13;
  localparam logic [4:0] IDX_PAD = 5'h14;

  // Index register fields
  localparam int IDX_PAL_EN_BIT = 5;
  // Mode control fields
  localparam int MODE_GFX_BIT = 0;
  localparam int MODE_MONO_BIT = 1;
  localparam int MODE_LGC_BIT = 2;
  localparam int MODE_BLINK_BIT = 3;
  localparam int MODE_TOPPAN_BIT = 5;
  localparam int MODE_BYTE_BIT = 6;
  localparam int MODE_V54_BIT = 7;
  localparam logic [7:0] MODE_WR_MASK = 8'hEF;

  localparam logic [5:0] RST_INDEX = 6'h00;
  localparam logic [7:0] RST_MODE = 8'h00;
  localparam logic [7:0] RST_BORDER = 8'h00;
  localparam logic [5:0] RST_PALETTE = 6'h00;
  localparam logic [3:0] RST_PAN = 4'h0;
  localparam logic [3:0] RST_PAD = 4'h0;

  localparam logic [7:0] LGC_FIRST = 8'hC0;
  localparam logic [7:0] LGC_LAST = 8'hDF;

  // Blink divider: 32 retraces, char phase bit 4, cursor phase bit 3
  localparam int BLINK_W = 5;
  localparam int CHAR_BLINK_BIT = 4;
  localparam int CURSOR_BLINK_BIT = 3;

  localparam int PAL_ENTRIES = 16;

  typedef enum logic {PH_FIRST, PH_SECOND} vac_phase_type;
endpackage : vac_pkg

/* File: src/vac_timing_if.sv */
// Carrier between the controller core and its blink and pan timer.
`timescale 1ns/1ps
interface vac_timing_if;
  logic retracePulse;
  logic lineCmpMatch;
  logic vsyncStart;
  logic topPanEn;
  logic charBlinkOff;
  logic cursorBlinkOn;
  logic panZero;
  modport timer (
    input retracePulse,
    input lineCmpMatch,
    input vsyncStart,
    input topPanEn,
    output charBlinkOff,
    output cursorBlinkOn,
    output panZero
  );
  modport core (
    output retracePulse,
    output lineCmpMatch,
    output vsyncStart,
    output topPanEn,
    input charBlinkOff,
    input cursorBlinkOn,
    input panZero
  );
endinterface : vac_timing_if

/* File: testbench/vac_attribute_controller_asserts.sv */
// Port-level checks of the attribute controller host port and pixel strobe.
`timescale 1ns/1ps
module vac_attribute_controller_asserts
  import vac_pkg::*;
(
  input wire logic clock,
  input wire logic rst_n,
  input wire logic [15:0] ioAddr,
  input wire logic ioRd,
  input wire logic ioWr,
  input wire logic [7:0] ioWdata,
  input wire logic [7:0] ioRdata,
  input wire logic [7:0] pixelOut,
  input wire logic pixelStrobe
);
  // Last two bytes written at any I/O address
  logic [7:0] wr1_q, wr2_q;
  always_ff @(posedge clock) begin
    if (ioWr) begin
      wr1_q <= ioWdata;
      wr2_q <= wr1_q;
    end
  end
  default clocking @(posedge clock); endclocking
  default disable iff (!rst_n);
  sequence s_clr;
    ioRd && !ioWr && (ioAddr == ADDR_STAT_MONO || ioAddr == ADDR_STAT_COLOR);
  endsequence
  sequence s_wr;
    ioWr && !ioRd && ioAddr == ADDR_INDEX;
  endsequence
  sequence s_rdi;
    ioRd && !ioWr && ioAddr == ADDR_INDEX;
  endsequence
  sequence s_rdd;
    ioRd && !ioWr && ioAddr == ADDR_DATA_RD;
  endsequence
  property p_preset;
    s_clr ##1 s_wr ##1 s_rdi |=> ioRdata == {2'b00, wr1_q[5:0]};
  endproperty
  a_preset: assert property (p_preset) else $error("index after preset wrong");
  property p_flip;
    s_clr ##1 s_wr ##1 s_wr ##1 s_rdi |=> ioRdata == {2'b00, wr2_q[5:0]};
  endproperty
  a_flip: assert property (p_flip) else $error("second write hit index");
  property p_rdkeep;
    s_clr ##1 s_wr ##1 s_rdd ##1 s_wr ##1 s_rdi |=> ioRdata == {2'b00, wr2_q[5:0]};
  endproperty
  a_rdkeep: assert property (p_rdkeep) else $error("read moved the toggle");
  property p_mode;
    s_clr ##1 (ioWr && !ioRd && ioAddr == ADDR_INDEX && ioWdata[4:0] == IDX_MODE) ##1 s_wr ##1 s_rdd
      |=> ioRdata == (wr1_q & MODE_WR_MASK);
  endproperty
  a_mode: assert property (p_mode) else $error("mode readback wrong");
  property p_unmap;
    s_clr ##1 (ioWr && !ioRd && ioAddr == ADDR_INDEX && ioWdata[4:0] > IDX_PAD) ##1 s_rdd |=> ioRdata == 8'h00;
  endproperty
  a_unmap: assert property (p_unmap) else $error("unmapped index not zero");
  property p_hold;
    !(ioRd && (ioAddr == ADDR_INDEX || ioAddr == ADDR_DATA_RD)) |=> $stable(ioRdata);
  endproperty
  a_hold: assert property (p_hold) else $error("read data moved");
  property p_pair;
    $fell(pixelStrobe) |=> pixelStrobe;
  endproperty
  a_pair: assert property (p_pair) else $error("strobe gap over one dot");
  property p_still;
    !pixelStrobe |-> $stable(pixelOut);
  endproperty
  a_still: assert property (p_still) else $error("pixel moved without strobe");
endmodule : vac_attribute_controller_asserts

bind vac_attribute_controller vac_attribute_controller_asserts i_chk (.clock, .rst_n, .ioAddr, .ioRd, .ioWr,
  .ioWdata, .ioRdata, .pixelOut, .pixelStrobe);

/* File: testbench/vac_attribute_controller_tb.sv */
// Self-checking bench for the attribute controller.
`timescale 1ns/1ps
`define CHK(nm, ex, gt) begin checked++; if ((gt) !== (ex)) begin failCount++; \
  $display("[FAIL] %s exp %h got %h", nm, ex, gt); end end
module vac_attribute_controller_tb;
  import vac_pkg::*;
  logic clock = 1'b0, rst_n = 1'b0, pixelWidthCtrl = 1'b1, borderActive = 1'b0;
  logic fontDot = 1'b0, ninthColumn = 1'b0, eighthDot = 1'b0, cursorDot = 1'b0, underlineRow = 1'b0;
  logic verticalRetracePulse = 1'b0, lineCmpMatch = 1'b0, vsyncStart = 1'b0;
  logic [7:0] charCode = 8'h00, attrByte = 8'h00;
  logic [3:0] videoNibble = 4'h0;
  logic [15:0] ioAddr;
  logic ioRd, ioWr, pixelStrobe;
  logic [7:0] ioWdata, ioRdata, pixelOut, got, pad, bdr, v;
  logic [3:0] panOut, nib, nb2;
  logic [5:0] pal [16];
  int failCount = 0, checked = 0, cycles = 0;

  vac_attribute_controller i_dut (.clock, .rst_n, .ioAddr, .ioRd, .ioWr, .ioWdata, .ioRdata, .pixelWidthCtrl,
    .fontDot, .ninthColumn, .eighthDot, .cursorDot, .underlineRow, .charCode, .attrByte, .videoNibble,
    .borderActive, .verticalRetracePulse, .lineCmpMatch, .vsyncStart, .pixelOut, .pixelStrobe, .panOut);
  vac_host_model i_host (.clock, .ioAddr, .ioRd, .ioWr, .ioWdata);

  always #20 clock = ~clock;
  always @(posedge clock) begin
    cycles++;
    if (cycles == 5000) begin
      failCount++;
      tally_and_finish();
    end
  end

  function automatic logic [7:0] exp_pix(logic [5:0] p, logic v54);
    return {pad[3:2], v54 ? pad[1:0] : p[5:4], p[3:0]};
  endfunction : exp_pix

  // Status read first so the index lands in the index register
  task automatic acc(input logic [7:0] idx, input logic [7:0] val, input logic dowr, output logic [7:0] rd);
    i_host.xfer(1'b1, 1'b0, $urandom_range(1) ? ADDR_STAT_MONO : ADDR_STAT_COLOR, 8'h00);
    i_host.xfer(1'b0, 1'b1, ADDR_INDEX, idx);
    if (dowr) i_host.xfer(1'b0, 1'b1, ADDR_INDEX, val);
    i_host.xfer(1'b1, 1'b0, ADDR_DATA_RD, 8'h00);
    rd = ioRdata;
    i_host.idle();
  endtask : acc

  task automatic tick(int n);
    repeat (n) @(posedge clock);
    #1;
  endtask : tick

  task automatic retrace(int n);
    repeat (n) begin
      verticalRetracePulse = 1'b1;
      tick(1);
      verticalRetracePulse = 1'b0;
      tick(1);
    end
  endtask : retrace

  // One text dot; controls are {font, ninth, eighth, cursor, underline}
  task automatic dot(input logic [4:0] ctl, input logic [7:0] cc, input logic [7:0] at, input logic [3:0] code);
    {fontDot, ninthColumn, eighthDot, cursorDot, underlineRow} = ctl;
    charCode = cc;
    attrByte = at;
    tick(1);
    `CHK("text", exp_pix(pal[code], 1'b0), pixelOut)
  endtask : dot

  task automatic tally_and_finish();
    $display("checks %0d mismatches %0d", checked, failCount);
    if (failCount == 0 && checked > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask : tally_and_finish

  initial begin
    void'($urandom(54));
    tick(6);
    rst_n = 1'b1;
    `CHK("panOut", 4'h0, panOut)
    acc({3'b001, IDX_MODE}, 8'h00, 1'b0, got);
    `CHK("mode", 8'h00, got)
    acc({3'b001, IDX_BORDER}, 8'h00, 1'b0, got);
    `CHK("border", 8'h00, got)
    $display("test reset done");
    for (int k = 0; k < 8; k++) begin
      v = 8'($urandom);
      acc({3'b001, IDX_MODE}, v, 1'b1, got);
      `CHK("mode", v & MODE_WR_MASK, got)
      acc({3'b001, IDX_BORDER}, v, 1'b1, got);
      `CHK("border", v, got)
      acc({3'b001, IDX_PAN}, v, 1'b1, got);
      `CHK("pan", v & 8'h0F, got)
      acc({3'b001, 5'(21 + k)}, v, k[0], got);
      `CHK("unmapped", 8'h00, got)
    end
    i_host.xfer(1'b1, 1'b0, ADDR_STAT_MONO, 8'h00);
    i_host.xfer(1'b0, 1'b1, ADDR_INDEX, 8'hD2);
    i_host.xfer(1'b1, 1'b0, ADDR_INDEX, 8'h00);
    `CHK("index", 8'h12, ioRdata)
    i_host.xfer(1'b1, 1'b0, ADDR_STAT_COLOR, 8'h00);
    i_host.xfer(1'b0, 1'b1, ADDR_INDEX, 8'h31);
    i_host.xfer(1'b0, 1'b1, ADDR_INDEX, 8'h5A);
    i_host.xfer(1'b1, 1'b0, ADDR_INDEX, 8'h00);
    `CHK("index", 8'h31, ioRdata)
    i_host.xfer(1'b1, 1'b0, ADDR_STAT_COLOR, 8'h00);
    i_host.xfer(1'b0, 1'b1, ADDR_INDEX, 8'h31);
    i_host.xfer(1'b1, 1'b0, ADDR_DATA_RD, 8'h00);
    `CHK("border", 8'h5A, ioRdata)
    i_host.xfer(1'b0, 1'b1, ADDR_INDEX, 8'hA5);
    i_host.xfer(1'b1, 1'b0, ADDR_INDEX, 8'h00);
    `CHK("index", 8'h31, ioRdata)
    i_host.idle();
    acc(8'h31, 8'h00, 1'b0, got);
    `CHK("border", 8'hA5, got)
    $display("test toggle done");
    for (int i = 0; i < 16; i++) begin
      pal[i] = 6'($urandom);
      acc(8'(i), {2'b11, pal[i]}, 1'b1, got);
      `CHK("palette", {2'b00, pal[i]}, got)
    end
    pad = 8'($urandom);
    acc({3'b001, IDX_PAD}, pad, 1'b1, got);
    for (int m = 0; m < 2; m++) begin
      acc({3'b001, IDX_MODE}, {m[0], 7'h01}, 1'b1, got);
      for (int k = 0; k < 20; k++) begin
        nib = 4'($urandom);
        videoNibble = nib;
        {fontDot, ninthColumn, eighthDot, cursorDot, underlineRow} = 5'($urandom);
        charCode = 8'($urandom);
        attrByte = 8'($urandom);
        tick(1);
        `CHK("pixel", exp_pix(pal[nib], m[0]), pixelOut)
        `CHK("strobe", 1'b1, pixelStrobe)
      end
    end
    acc({3'b001, IDX_MODE}, 8'h09, 1'b1, got);
    for (int ph = 0; ph < 2; ph++) begin
      tick(1);
      `CHK("blink", exp_pix(pal[nib ^ {ph[0], 3'b000}], 1'b0), pixelOut)
      retrace(16);
    end
    $display("test pixel done");
    pixelWidthCtrl = 1'b0;
    bdr = 8'($urandom);
    acc({3'b001, IDX_BORDER}, bdr, 1'b1, got);
    acc(8'h23, 8'h00, 1'b0, got);
    `CHK("blocked", 8'h00, got)
    acc(8'h03, 8'h00, 1'b0, got);
    `CHK("palette", {2'b00, pal[3]}, got)
    `CHK("nopal", bdr, pixelOut)
    borderActive = 1'b1;
    acc({3'b001, IDX_MODE}, 8'h41, 1'b1, got);
    `CHK("border", bdr, pixelOut)
    {nib, nb2} = 8'($urandom);
    borderActive = 1'b0;
    videoNibble = nib;
    tick(1);
    `CHK("strobe", 1'b0, pixelStrobe)
    videoNibble = nb2;
    tick(1);
    `CHK("byte", {nib, nb2}, pixelOut)
    $display("test byte done");
    acc({3'b001, IDX_PAN}, 8'h05, 1'b1, got);
    for (int m = 0; m < 2; m++) begin
      acc({3'b001, IDX_MODE}, m ? 8'h01 : 8'h21, 1'b1, got);
      lineCmpMatch = 1'b1;
      tick(1);
      lineCmpMatch = 1'b0;
      tick(1);
      `CHK("pan", m ? 4'h5 : 4'h0, panOut)
      vsyncStart = 1'b1;
      tick(1);
      vsyncStart = 1'b0;
      tick(1);
      `CHK("pan", 4'h5, panOut)
    end
    $display("test pan done");
    pixelWidthCtrl = 1'b1;
    v = 8'($urandom) | 8'h80;
    acc({3'b001, IDX_MODE}, 8'h04, 1'b1, got);
    dot(5'b10000, 8'h41, v, v[3:0]);
    dot(5'b00000, 8'h41, v, v[7:4]);
    dot(5'b01100, 8'hC5, v, v[3:0]);
    dot(5'b01100, 8'hE0, v, v[7:4]);
    dot(5'b00010, 8'h41, v, v[3:0]);
    acc({3'b001, IDX_MODE}, 8'h00, 1'b1, got);
    dot(5'b01100, 8'hC5, v, v[7:4]);
    acc({3'b001, IDX_MODE}, 8'h0C, 1'b1, got);
    dot(5'b00000, 8'h41, v, {1'b0, v[6:4]});
    retrace(8);
    dot(5'b00010, 8'h41, v, {1'b0, v[6:4]});
    retrace(8);
    dot(5'b10000, 8'h41, v, {1'b0, v[6:4]});
    acc({3'b001, IDX_MODE}, 8'h02, 1'b1, got);
    dot(5'b10000, 8'h41, 8'h70, 4'h0);
    dot(5'b00000, 8'h41, 8'hF0, 4'hF);
    dot(5'b00001, 8'h41, 8'h09, 4'hF);
    $display("test text done");
    tally_and_finish();
  end
endmodule : vac_attribute_controller_tb

/* File: testbench/vac_host_model.sv */
// Host model issuing single-cycle I/O reads and writes.
`timescale 1ns/1ps
module vac_host_model (
  input wire logic clock,
  output logic [15:0] ioAddr,
  output logic ioRd,
  output logic ioWr,
  output logic [7:0] ioWdata
);
  initial begin
    ioAddr = 16'h0000;
    ioRd = 1'b0;
    ioWr = 1'b0;
    ioWdata = 8'h00;
  end
  // Calls chain back to back; each holds until its sampling edge
  task automatic xfer(input logic rd, input logic wr, input logic [15:0] a, input logic [7:0] d);
    ioRd = rd;
    ioWr = wr;
    ioAddr = a;
    ioWdata = d;
    @(posedge clock);
    #1;
  endtask : xfer
  // Strobes drop; address and data show inverted values so a stale match cannot pass
  task automatic idle();
    ioRd = 1'b0;
    ioWr = 1'b0;
    ioAddr = ~ioAddr;
    ioWdata = ~ioWdata;
    @(posedge clock);
    #1;
  endtask : idle
endmodule : vac_host_model
